// *** core/servo_axis_pkg.sv ***
// Constants, encodings and reset values of one analog servo axis.
// Assumes one 25 MHz clock and an asynchronous active-low reset.
//
// Function
// - Speed command only valid while enable asserted
// - Enable is active-low open-collector pulldown
// - Overload high drops ready and enable
// - Skip bit masks amplifier ready check
// - Quadrature count: B leads up, A leads down
// - External and butt reference modes without marker
package servo_axis_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int CMD_W = 16;                       // Digital speed command
   localparam int POS_W = 32;                       // Position counter

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [POS_W-1:0] POS_RESET      = 32'h0000_0000;
   localparam logic [CMD_W-1:0] CMD_IDLE       = 16'h0000;
   localparam logic [POS_W-1:0] POS_REFERENCE  = 32'h0000_0000; // Loaded on reference set
   localparam logic [1:0]       PIN_SYNC_RESET = 2'h3;          // Overload and ready return start released
   localparam logic [2:0]       ENC_SYNC_RESET = 3'h0;          // Phases A, B and marker

   // ----------------------------------------------------------------
   // Quadrature step codes: difference of phase codes
   // ----------------------------------------------------------------
   localparam logic [1:0] STEP_UP   = 2'h1;
   localparam logic [1:0] STEP_BOTH = 2'h2;
   localparam logic [1:0] STEP_DOWN = 2'h3;

   // ----------------------------------------------------------------
   // Reference position setting
   // ----------------------------------------------------------------
   localparam logic [1:0] REF_MODE_MARKER   = 2'h0;
   localparam logic [1:0] REF_MODE_EXTERNAL = 2'h1;
   localparam logic [1:0] REF_MODE_BUTT     = 2'h2;

   typedef enum logic [1:0] {
      REF_IDLE  = 2'b00,
      REF_ARMED = 2'b01,
      REF_DONE  = 2'b11
   } ref_state_e;

endpackage

// *** core/pin_sync.sv ***
// Two-stage synchroniser for a group of pins.
// Assumes the inputs may change at any time relative to i_sys_clk.
module pin_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_resetn,
   // Pins
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   logic [W-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta   <= RST;
         o_sync <= RST;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end

endmodule // pin_sync

// *** core/analog_servo_axis_interface.sv ***
// Per-axis logic toward an analog servo amplifier and its pulse encoder:
// ready and enable handshake, speed command gating, overload monitoring,
// quadrature position count and reference position setting.
// Assumes amplifier and encoder pins are synchronised here; open-collector
// drivers and pull-ups sit outside and turn each output enable into a line level.
module analog_servo_axis_interface
   import servo_axis_pkg::*;
(
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_resetn,
   // Controller side
   input  wire logic             i_servo_on,
   input  wire logic [CMD_W-1:0] i_speed_command_ref,
   input  wire logic             i_skip_amp_ready_check,
   // Reference setting control
   input  wire logic [1:0]       i_ref_mode,
   input  wire logic             i_ref_arm,
   input  wire logic             i_ref_ext_trigger,
   input  wire logic             i_butt_stop,
   // Amplifier pins
   input  wire logic             i_overload_alarm_in,
   input  wire logic             i_amp_ready_return_n,
   output logic                  o_ctrl_ready_n_out,
   output logic                  o_ctrl_ready_n_oe,
   output logic                  o_amp_enable_n_out,
   output logic                  o_amp_enable_n_oe,
   // Encoder pins
   input  wire logic             i_enc_a,
   input  wire logic             i_enc_b,
   input  wire logic             i_enc_z,
   // Controller results
   output logic [CMD_W-1:0]      o_speed_command_out,
   output logic                  o_speed_valid,
   output logic                  o_overload,
   output logic                  o_amp_fault,
   output logic [POS_W-1:0]      o_position,
   output logic                  o_phase_error,
   output logic                  o_ref_set,
   output logic                  o_ref_done
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] amp_sync;
   logic [2:0] enc_sync;
   logic       ovl_s;
   logic       amp_ready_s;
   logic       enc_a_s;
   logic       enc_b_s;
   logic       enc_z_s;

   pin_sync #(.W(2), .RST(PIN_SYNC_RESET)) u_amp_sync (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_async   ({i_overload_alarm_in, i_amp_ready_return_n}),
      .o_sync    (amp_sync)
   );

   pin_sync #(.W(3), .RST(ENC_SYNC_RESET)) u_enc_sync (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_async   ({i_enc_a, i_enc_b, i_enc_z}),
      .o_sync    (enc_sync)
   );

   // Released overload line reads high and counts as alarm
   assign ovl_s       = amp_sync[1];
   assign amp_ready_s = ~amp_sync[0];
   assign enc_a_s     = enc_sync[2];
   assign enc_b_s     = enc_sync[1];
   assign enc_z_s     = enc_sync[0];

   // ----------------------------------------------------------------
   // Ready, enable and speed command
   // ----------------------------------------------------------------
   logic             ctrl_ready;
   logic             amp_enable;
   logic [CMD_W-1:0] speed_cmd;
   logic             next_ctrl_ready;
   logic             next_amp_enable;
   logic [CMD_W-1:0] next_speed_cmd;
   logic             next_amp_fault;

   // Handshake decisions from synchronised amplifier lines
   always_comb begin
      next_ctrl_ready = i_servo_on && !ovl_s;
      next_amp_enable = next_ctrl_ready && (amp_ready_s || i_skip_amp_ready_check);
      next_speed_cmd  = next_amp_enable ? i_speed_command_ref : CMD_IDLE;
      next_amp_fault  = ctrl_ready && !amp_ready_s && !i_skip_amp_ready_check;
   end

   // Handshake registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_ready  <= 1'b0;
         amp_enable  <= 1'b0;
         speed_cmd   <= CMD_IDLE;
         o_amp_fault <= 1'b0;
         o_overload  <= 1'b0;
      end else begin
         ctrl_ready  <= next_ctrl_ready;
         amp_enable  <= next_amp_enable;
         speed_cmd   <= next_speed_cmd;
         o_amp_fault <= next_amp_fault;
         o_overload  <= ovl_s;
      end
   end

   // Open-collector lines: data held low, enable pulls the line to 0 V
   assign o_ctrl_ready_n_out  = 1'b0;
   assign o_ctrl_ready_n_oe   = ctrl_ready;
   assign o_amp_enable_n_out  = 1'b0;
   assign o_amp_enable_n_oe   = amp_enable;
   assign o_speed_command_out = speed_cmd;
   assign o_speed_valid       = amp_enable;

   // ----------------------------------------------------------------
   // Quadrature decoder
   // ----------------------------------------------------------------
   logic [1:0]       phase_code;
   logic [1:0]       prev_code;
   logic [1:0]       step;
   logic             step_up;
   logic             step_down;
   logic             step_both;
   logic             prev_z;
   logic             marker_rise;
   logic [POS_W-1:0] position;
   logic [POS_W-1:0] next_position;
   logic             phase_error;
   logic             next_phase_error;
   logic             ref_load;

   // Phase code counts up along 00,01,11,10 as B leads A
   always_comb begin
      phase_code  = {enc_a_s, enc_a_s ^ enc_b_s};
      step        = phase_code - prev_code;
      step_up     = (step == STEP_UP);
      step_down   = (step == STEP_DOWN);
      step_both   = (step == STEP_BOTH);
      marker_rise = enc_z_s && !prev_z;
   end

   // Position count, reference load has priority over a step
   always_comb begin
      next_position    = position;
      next_phase_error = step_both;
      if (ref_load) begin
         next_position = POS_REFERENCE;
      end else if (step_up) begin
         next_position = position + POS_W'(1);
      end else if (step_down) begin
         next_position = position - POS_W'(1);
      end
   end

   // Decoder registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         prev_code   <= 2'h0;
         prev_z      <= 1'b0;
         position    <= POS_RESET;
         phase_error <= 1'b0;
      end else begin
         prev_code   <= phase_code;
         prev_z      <= enc_z_s;
         position    <= next_position;
         phase_error <= next_phase_error;
      end
   end

   assign o_position    = position;
   assign o_phase_error = phase_error;

   // ----------------------------------------------------------------
   // Reference position setting
   // ----------------------------------------------------------------
   ref_state_e ref_state;
   ref_state_e next_ref_state;
   logic       ref_set;
   logic       next_ref_set;
   logic       ref_done;
   logic       next_ref_done;

   // Marker mode waits for the one-rotation pulse, the others need none
   always_comb begin
      next_ref_state = ref_state;
      ref_load       = 1'b0;
      case (ref_state)
         REF_IDLE, REF_DONE: begin
            if (i_ref_arm) begin
               next_ref_state = REF_ARMED;
            end
         end
         REF_ARMED: begin
            case (i_ref_mode)
               REF_MODE_MARKER:   ref_load = marker_rise;
               REF_MODE_EXTERNAL: ref_load = i_ref_ext_trigger;
               REF_MODE_BUTT:     ref_load = i_butt_stop;
               default:           ref_load = 1'b0;
            endcase
            if (ref_load) begin
               next_ref_state = REF_DONE;
            end
         end
         default: next_ref_state = REF_IDLE;
      endcase
      next_ref_set = ref_load;
      next_ref_done = (next_ref_state == REF_DONE);
   end

   // Reference registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ref_state <= REF_IDLE;
         ref_set   <= 1'b0;
         ref_done  <= 1'b0;
      end else begin
         ref_state <= next_ref_state;
         ref_set   <= next_ref_set;
         ref_done  <= next_ref_done;
      end
   end

   assign o_ref_set  = ref_set;
   assign o_ref_done = ref_done;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_speed_gated;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      !o_amp_enable_n_oe |-> (o_speed_command_out == CMD_IDLE) && !o_speed_valid;
   endproperty
   a_speed_gated: assert property (p_speed_gated) else $error("speed command live while disabled");

   property p_enable_pulls_low;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(o_amp_enable_n_oe) |-> (o_amp_enable_n_out == 1'b0);
   endproperty
   a_enable_pulls_low: assert property (p_enable_pulls_low) else $error("enable does not pull low");

   property p_overload_drops;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(i_overload_alarm_in) ##1 i_overload_alarm_in [*2]
         |=> !o_ctrl_ready_n_oe && !o_amp_enable_n_oe && o_overload;
   endproperty
   a_overload_drops: assert property (p_overload_drops) else $error("overload did not drop ready");

   property p_skip_check;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_servo_on && !ovl_s && i_skip_amp_ready_check) |=> o_amp_enable_n_oe && !o_amp_fault;
   endproperty
   a_skip_check: assert property (p_skip_check) else $error("skip bit did not mask ready");

   property p_count_dir;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (step_up && !ref_load) |=> (o_position == $past(o_position) + POS_W'(1));
   endproperty
   a_count_dir: assert property (p_count_dir) else $error("B-leading step not counted up");

   property p_ref_external;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (ref_state == REF_ARMED && i_ref_mode == REF_MODE_EXTERNAL && i_ref_ext_trigger)
         |=> o_ref_set && o_ref_done && (o_position == POS_REFERENCE);
   endproperty
   a_ref_external: assert property (p_ref_external) else $error("external reference not taken");

   property p_double_ignored;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (step_both && !ref_load) |=> $stable(o_position) && o_phase_error;
   endproperty
   a_double_ignored: assert property (p_double_ignored) else $error("double transition counted");

   property p_enable_needs_ready;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      o_amp_enable_n_oe |-> o_ctrl_ready_n_oe && $past(amp_ready_s || i_skip_amp_ready_check);
   endproperty
   a_enable_needs_ready: assert property (p_enable_needs_ready) else $error("enable without ready");

endmodule // analog_servo_axis_interface

// *** testbench/amp_encoder_model.sv ***
// Behavioural analog servo amplifier with its pulse encoder.
// Assumes open-collector lines already resolved to levels by the bench.
module amp_encoder_model (
   // Clock
   input  wire logic        i_sys_clk,
   // Lines from the axis logic
   input  wire logic        i_ctrl_ready_line,
   input  wire logic        i_amp_enable_line,
   input  wire logic [15:0] i_speed_command,
   // Lines to the axis logic
   output logic             o_overload_alarm_in,
   output logic             o_amp_ready_return_n,
   output logic             o_enc_a,
   output logic             o_enc_b,
   output logic             o_enc_z
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        alarm = 1'b0;
   logic        fault = 1'b0;
   logic [1:0]  phase = 2'h0;
   logic [15:0] motor_speed;

   // ----------------------------------------------------------------
   // Amplifier
   // ----------------------------------------------------------------
   // Unused alarm sits tied low; a raised alarm releases the line high
   assign o_overload_alarm_in  = alarm;
   // Return shorted low at once after ready, released on internal error
   assign o_amp_ready_return_n = !(i_ctrl_ready_line === 1'b0 && !fault);
   // Motor stops on alarm or error whatever the command
   assign motor_speed = (alarm || fault || i_amp_enable_line !== 1'b0) ? 16'h0000 : i_speed_command;

   // ----------------------------------------------------------------
   // Encoder
   // ----------------------------------------------------------------
   // Phase index 0..3 walks 00,01,11,10 on {A,B}: upward means B leads
   assign o_enc_a = phase[1];
   assign o_enc_b = phase[1] ^ phase[0];
   initial o_enc_z = 1'b0;

   // Steps the phases, two clocks apart; inc 2 makes both phases flip
   task automatic step(input int n, input logic [1:0] inc);
      repeat (n) begin
         repeat (2) @(posedge i_sys_clk);
         phase <= phase + inc;
      end
   endtask

   // Marker pulse spans a full phase period while turning upward
   task automatic marker();
      @(posedge i_sys_clk);
      o_enc_z <= 1'b1;
      step(4, 2'h1);
      @(posedge i_sys_clk);
      o_enc_z <= 1'b0;
   endtask
endmodule // amp_encoder_model

// *** testbench/tb_top.sv ***
// Self-checking bench of one analog servo axis.
// Assumes a partner model of the amplifier and encoder on the pins.
module tb_top;
   import servo_axis_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_sys_clk, i_resetn, servo_on, skip, arm, ext_trig, butt;
   logic [CMD_W-1:0] cmd;
   logic [1:0] mode;
   logic ovl_in, rdy_ret_n, ena, enb, enz;
   logic rdy_out, rdy_oe, en_out, en_oe, valid, overload_alarm_in, fault, perr, rset, rdone;
   logic rdy_line, en_line;
   logic [CMD_W-1:0] spd;
   logic [POS_W-1:0] pos, base;
   int err_total = 0;
   int compares = 0;
   int perr_cnt = 0;
   int rset_cnt = 0;

   // ----------------------------------------------------------------
   // Clock, reset, lines
   // ----------------------------------------------------------------
   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end
   // Pull-ups hold released lines high
   assign rdy_line = rdy_oe ? rdy_out : 1'b1;
   assign en_line  = en_oe ? en_out : 1'b1;
   // Count one-cycle pulses; scenarios compare against a snapshot
   always @(posedge i_sys_clk) begin
      if (perr === 1'b1) perr_cnt <= perr_cnt + 1;
      if (rset === 1'b1) rset_cnt <= rset_cnt + 1;
   end

   analog_servo_axis_interface DUT (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_servo_on(servo_on),
      .i_speed_command_ref(cmd), .i_skip_amp_ready_check(skip), .i_ref_mode(mode),
      .i_ref_arm(arm), .i_ref_ext_trigger(ext_trig), .i_butt_stop(butt),
      .i_overload_alarm_in(ovl_in), .i_amp_ready_return_n(rdy_ret_n),
      .o_ctrl_ready_n_out(rdy_out), .o_ctrl_ready_n_oe(rdy_oe),
      .o_amp_enable_n_out(en_out), .o_amp_enable_n_oe(en_oe),
      .i_enc_a(ena), .i_enc_b(enb), .i_enc_z(enz), .o_speed_command_out(spd),
      .o_speed_valid(valid), .o_overload(overload_alarm_in), .o_amp_fault(fault), .o_position(pos),
      .o_phase_error(perr), .o_ref_set(rset), .o_ref_done(rdone));

   amp_encoder_model amp (
      .i_sys_clk(i_sys_clk), .i_ctrl_ready_line(rdy_line), .i_amp_enable_line(en_line),
      .i_speed_command(spd), .o_overload_alarm_in(ovl_in), .o_amp_ready_return_n(rdy_ret_n),
      .o_enc_a(ena), .o_enc_b(enb), .o_enc_z(enz));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Enable line state: pulled low exactly while enabled
   task automatic chk_en(input logic exp);
      chk("enable_oe", {31'h0, exp}, {31'h0, en_oe});
      chk("enable_out", 32'h0, {31'h0, en_out});
      chk("speed", exp ? {16'h0, cmd} : 32'h0, {16'h0, spd});
      chk("valid", {31'h0, exp}, {31'h0, valid});
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_handshake;
      cyc(6);
      chk_en(1'b0);
      @(posedge i_sys_clk);
      cmd <= 16'h8a5c;
      servo_on <= 1'b1;
      cyc(6);
      chk("ready_oe", 32'h1, {31'h0, rdy_oe});
      chk_en(1'b1);
      chk("ready_out", 32'h0, {31'h0, rdy_out});
      chk("motor_run", {16'h0, cmd}, {16'h0, amp.motor_speed});
      $display("test handshake done");
   endtask
   task automatic t_overload;
      @(posedge i_sys_clk);
      amp.alarm <= 1'b1;
      cyc(6);
      chk("ready_oe", 32'h0, {31'h0, rdy_oe});
      chk("overload", 32'h1, {31'h0, overload_alarm_in});
      chk_en(1'b0);
      chk("motor_alarm", 32'h0, {16'h0, amp.motor_speed});
      @(posedge i_sys_clk);
      amp.alarm <= 1'b0;
      cyc(10);
      chk("overload_clr", 32'h0, {31'h0, overload_alarm_in});
      chk_en(1'b1);
      $display("test overload done");
   endtask
   task automatic t_fault;
      @(posedge i_sys_clk);
      amp.fault <= 1'b1;
      cyc(6);
      chk("fault", 32'h1, {31'h0, fault});
      chk_en(1'b0);
      chk("motor_fault", 32'h0, {16'h0, amp.motor_speed});
      @(posedge i_sys_clk);
      skip <= 1'b1;
      cyc(4);
      chk_en(1'b1);
      chk("fault_masked", 32'h0, {31'h0, fault});
      @(posedge i_sys_clk);
      amp.fault <= 1'b0;
      skip <= 1'b0;
      cyc(6);
      chk_en(1'b1);
      $display("test fault done");
   endtask
   task automatic t_encoder;
      int perr_base;
      base = pos;
      amp.step(5, 2'h1);
      cyc(6);
      chk("pos_up", base + 32'h5, pos);
      amp.step(7, 2'h3);
      cyc(6);
      chk("pos_down", base - 32'h2, pos);
      perr_base = perr_cnt;
      amp.step(1, 2'h2);
      cyc(6);
      chk("phase_err", 32'h1, perr_cnt - perr_base);
      chk("pos_double", base - 32'h2, pos);
      $display("test encoder done");
   endtask
   // Loads reference in one mode; marker mode keeps counting after the load
   task automatic t_ref(input logic [1:0] m);
      int rset_base;
      amp.step(3, 2'h1);
      rset_base = rset_cnt;
      @(posedge i_sys_clk);
      mode <= m;
      arm <= 1'b1;
      @(posedge i_sys_clk);
      arm <= 1'b0;
      ext_trig <= (m == REF_MODE_EXTERNAL);
      butt <= (m == REF_MODE_BUTT);
      if (m == REF_MODE_MARKER) amp.marker();
      @(posedge i_sys_clk);
      ext_trig <= 1'b0;
      butt <= 1'b0;
      cyc(6);
      chk("ref_set", 32'h1, rset_cnt - rset_base);
      chk("ref_done", 32'h1, {31'h0, rdone});
      chk("ref_pos", (m == REF_MODE_MARKER) ? POS_REFERENCE + 32'h4 : POS_REFERENCE, pos);
      $display("test reference mode %0d done", m);
   endtask
   // Triggers while not armed, or armed in the inert mode, load nothing
   task automatic t_refused(input logic [1:0] m);
      int rset_base;
      rset_base = rset_cnt;
      @(posedge i_sys_clk);
      mode <= m;
      arm <= (m == 2'h3);
      @(posedge i_sys_clk);
      arm <= 1'b0;
      ext_trig <= 1'b1;
      butt <= 1'b1;
      cyc(6);
      chk("refused_done", 32'h0, {31'h0, rdone});
      chk("refused_set", rset_base, rset_cnt);
      @(posedge i_sys_clk);
      ext_trig <= 1'b0;
      butt <= 1'b0;
      $display("test refused mode %0d done", m);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      i_resetn = 1'b0;
      {servo_on, skip, arm, ext_trig, butt} = 5'h00;
      cmd = CMD_IDLE;
      mode = REF_MODE_EXTERNAL;
      repeat (4) @(posedge i_sys_clk);
      #1;
      chk("rst_en", 32'h0, {30'h0, en_oe, rdy_oe});
      chk("rst_pos", 32'h0, pos);
      i_resetn <= 1'b1;
      t_handshake();
      t_overload();
      t_fault();
      t_encoder();
      t_refused(REF_MODE_EXTERNAL);
      t_ref(REF_MODE_EXTERNAL);
      t_ref(REF_MODE_BUTT);
      t_ref(REF_MODE_MARKER);
      t_refused(2'h3);
      final_report();
   end
   initial begin
      #(40 * 4000);
      err_total++;
      final_report();
   end
endmodule // tb_top
